// *** verilog/fap_ctrl.v ***
// Summary of operation
// - protected user mode: option bytes read only, boot area read and execute only
// - debug port with protection on blocks every access to every area except protection byte writes
// - debug port with protection on refuses option writes except protection byte
// - no boot area defined lets non-trap vectors be written in user mode
// - privileged area defined blocks trap vector writes in user mode
// - program memory stays write-locked until correct key pair arrives
// - clearing program-unlocked flag relocks program memory
// - only one program unlock between two resets
// - wrong program key blocks unlock attempts until reset
// - data area locked until correct data keys; clearing flag relocks
// - wrong data key allows a fresh key sequence without reset
// - option writes unlock by data keys only with option enable set
// - privileged area only read or executed in privileged mode, never debug
// - removing readout protection erases all memory and option bytes
// - run low-leak select with code running from RAM forces both memories low-leak until next access
// - hardware clears run low-leak select after next memory access
// - software clearing run low-leak select does not leave low-leak mode
// - wait low-leak select puts memories in low-leak during wait mode
// - interrupt enable raises memory interrupt on end or protected-write flag
// - fixed-time clear halves byte time if erased; set always full time
// - control register one at offset zero, resets zero, bits 7:4 reserved
// - protected write sets flag; status read clears it
// - write or erase end sets end flag; status read or new start clears
// - key registers read back zero
// - correct keys set unlocked flags; software writes zero to clear
`timescale 1ns/1ps
`include "fap_regs.vh"
module fap_ctrl #(
  parameter [7:0] KEY1 = `FAP_KEY1,
  parameter [7:0] KEY2 = `FAP_KEY2,
  parameter TPROG_NS = `FAP_TPROG_NS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire debug_active,
  input wire wait_mode,
  input wire run_from_ram,
  input wire privileged,
  input wire acc_valid,
  input wire [2:0] acc_area,
  input wire [1:0] acc_kind,
  input wire acc_rop_byte,
  input wire acc_erased,
  output reg acc_grant,
  output reg acc_start,
  output reg prog_busy,
  output reg prog_done,
  output reg mem_lowleak,
  output reg mem_irq,
  output reg erase_all
);
  // ========================================================
  // timing
  localparam integer FULL_CYC = (TPROG_NS + `FAP_CLK_NS - 1) / `FAP_CLK_NS;
  localparam integer HALF_CYC = (FULL_CYC + 1) / 2;
  localparam [15:0] FULL_C = FULL_CYC[15:0];
  localparam [15:0] HALF_C = HALF_CYC[15:0];
  // ========================================================
  // synchronised pins
  reg [1:0] dbg_s;
  reg [1:0] wait_s;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_s <= 2'h0;
      wait_s <= 2'h0;
    end else begin
      dbg_s <= {dbg_s[0], debug_active};
      wait_s <= {wait_s[0], wait_mode};
    end
  end
  wire dbg;
  wire wait_lowleak_select;
  assign dbg = dbg_s[1];
  assign wait_lowleak_select = wait_s[1];
  // ========================================================
  // apb decode
  wire wr_en;
  wire rd_en;
  wire [7:0] idx;
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign idx = paddr[`FAP_OFF_W-1:2];
  function hit;
    input [7:0] a;
    input [7:0] i;
    begin
      hit = (a == i) && (paddr[1:0] == 2'h0) &&
            (paddr[31:`FAP_OFF_W] == 22'h0);
    end
  endfunction
  wire mapped;
  assign mapped = hit(idx, `FAP_IDX_CR1) || hit(idx, `FAP_IDX_CR2) ||
                  hit(idx, `FAP_IDX_PKEY) || hit(idx, `FAP_IDX_DKEY) ||
                  hit(idx, `FAP_IDX_STAT) || hit(idx, `FAP_IDX_CFG) ||
                  hit(idx, `FAP_IDX_ACC) || hit(idx, `FAP_IDX_RES);
  assign pslverr = psel && penable && !mapped;
  // ========================================================
  // registers
  reg [7:0] cr1_q;
  reg opt_q;
  reg [3:0] cfg_q;
  reg eop_q;
  reg wpa_q;
  reg [2:0] last_area_q;
  reg last_deny_q;
  reg [15:0] cnt_q;
  reg run_ll_q;
  wire rop_on;
  wire ubc_def;
  wire priv_def;
  wire rop_clr;
  assign rop_on = cfg_q[0];
  assign ubc_def = cfg_q[1];
  assign priv_def = cfg_q[2];
  assign rop_clr = wr_en && hit(idx, `FAP_IDX_CFG) && rop_on && !pwdata[0];
  wire st_rd;
  assign st_rd = rd_en && hit(idx, `FAP_IDX_STAT);
  // ========================================================
  // key trackers
  wire pul;
  wire data_unlocked_flag;
  wire p_blk;
  wire d_blk;
  wire d_pulse;
  reg optul_q;
  wire st_wr;
  assign st_wr = wr_en && hit(idx, `FAP_IDX_STAT);
  fap_key_seq #(.KEY1(KEY1), .KEY2(KEY2), .ONCE(1'b1)) u_pkey (
    .pclk(pclk),
    .presetn(presetn),
    .key_wr(wr_en && hit(idx, `FAP_IDX_PKEY)),
    .key_data(pwdata[7:0]),
    .relock(st_wr && !pwdata[`FAP_ST_PUL]),
    .unlocked(pul),
    .blocked(p_blk),
    .unlock_pulse()
  );
  fap_key_seq #(.KEY1(KEY1), .KEY2(KEY2), .ONCE(1'b0)) u_dkey (
    .pclk(pclk),
    .presetn(presetn),
    .key_wr(wr_en && hit(idx, `FAP_IDX_DKEY)),
    .key_data(pwdata[7:0]),
    .relock(st_wr && !pwdata[`FAP_ST_DUL]),
    .unlocked(data_unlocked_flag),
    .blocked(d_blk),
    .unlock_pulse(d_pulse)
  );
  // ========================================================
  // access check
  reg ok;
  always @* begin
    ok = 1'b0;
    if (dbg && rop_on) begin
      // debug with protection: only protection byte writes pass
      ok = (acc_area == `FAP_AR_OPT) && (acc_kind == `FAP_AK_WR) &&
           acc_rop_byte && optul_q;
    end else begin
      case (acc_area)
        `FAP_AR_VEC: begin
          ok = (acc_kind != `FAP_AK_WR) ||
               (dbg || !ubc_def) && pul;
        end
        `FAP_AR_TRAP: begin
          ok = (acc_kind != `FAP_AK_WR) ||
               (dbg || (!priv_def && !ubc_def)) && pul;
        end
        `FAP_AR_PRIV: begin
          ok = (acc_kind != `FAP_AK_WR) && !dbg && privileged;
        end
        `FAP_AR_UBC: begin
          ok = (acc_kind != `FAP_AK_WR);
        end
        `FAP_AR_MAIN: begin
          ok = (acc_kind != `FAP_AK_WR) || pul;
        end
        `FAP_AR_DATA: begin
          ok = (acc_kind != `FAP_AK_EX) &&
               ((acc_kind == `FAP_AK_RD) || data_unlocked_flag);
        end
        `FAP_AR_OPT: begin
          ok = (acc_kind == `FAP_AK_RD) ||
               ((acc_kind == `FAP_AK_WR) && !rop_on && optul_q);
        end
        default: begin
          ok = 1'b0;
        end
      endcase
    end
  end
  wire is_wr;
  wire deny_wr;
  wire start;
  assign is_wr = acc_valid && (acc_kind == `FAP_AK_WR);
  // refused writes only raise a flag, no busy phase
  assign deny_wr = is_wr && !ok;
  assign start = is_wr && ok && !prog_busy;
  // ========================================================
  // sequential state
  wire [3:0] cfg_next;
  assign cfg_next = pwdata[3:0];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cr1_q <= `FAP_CR1_RST;
      opt_q <= 1'b0;
      cfg_q <= 4'h0;
      eop_q <= 1'b0;
      wpa_q <= 1'b0;
      optul_q <= 1'b0;
      cnt_q <= 16'h0000;
      run_ll_q <= 1'b0;
      last_area_q <= 3'h0;
      last_deny_q <= 1'b0;
      acc_grant <= 1'b0;
      acc_start <= 1'b0;
      prog_busy <= 1'b0;
      prog_done <= 1'b0;
      mem_lowleak <= 1'b0;
      mem_irq <= 1'b0;
      erase_all <= 1'b0;
    end else begin
      acc_grant <= acc_valid && ok;
      acc_start <= start;
      prog_done <= 1'b0;
      erase_all <= rop_clr;
      if (acc_valid) begin
        last_area_q <= acc_area;
        last_deny_q <= !ok;
      end
      if (wr_en && hit(idx, `FAP_IDX_CR1)) begin
        cr1_q <= pwdata[7:0] & `FAP_CR1_MASK;
      end else if (acc_valid && acc_area == `FAP_AR_MAIN) begin
        cr1_q[`FAP_CR1_RUNM] <= 1'b0;
      end else if (acc_valid) begin
        cr1_q[`FAP_CR1_RUNM] <= 1'b0;
      end
      if (wr_en && hit(idx, `FAP_IDX_CR2)) begin
        opt_q <= pwdata[`FAP_CR2_OPT];
      end
      if (rop_clr) begin
        // whole memory erase restores blank option bytes
        cfg_q <= 4'h0;
      end else if (wr_en && hit(idx, `FAP_IDX_CFG) && !(dbg && rop_on)) begin
        cfg_q <= cfg_next;
      end
      if (d_pulse) begin
        optul_q <= opt_q;
      end else if (!data_unlocked_flag) begin
        optul_q <= 1'b0;
      end
      // low-leak: leaves only on an access, never by clearing the bit
      if (acc_valid) begin
        run_ll_q <= 1'b0;
      end else if (cr1_q[`FAP_CR1_RUNM] && run_from_ram) begin
        run_ll_q <= 1'b1;
      end
      mem_lowleak <= (run_ll_q && !acc_valid) ||
                     (wait_lowleak_select && cr1_q[`FAP_CR1_WAIT_LOWLEAK_SELECT]);
      // programming timer
      if (start) begin
        prog_busy <= 1'b1;
        cnt_q <= (cr1_q[`FAP_CR1_FIX] || !acc_erased) ? FULL_C : HALF_C;
      end else if (prog_busy) begin
        if (cnt_q == 16'h0001) begin
          prog_busy <= 1'b0;
          prog_done <= 1'b1;
        end
        cnt_q <= cnt_q - 16'h0001;
      end
      // flags: set wins over clear
      if (prog_busy && cnt_q == 16'h0001) begin
        eop_q <= 1'b1;
      end else if (st_rd || start) begin
        eop_q <= 1'b0;
      end
      if (deny_wr) begin
        wpa_q <= 1'b1;
      end else if (st_rd) begin
        wpa_q <= 1'b0;
      end
      mem_irq <= cr1_q[`FAP_CR1_IE] && (eop_q || wpa_q);
    end
  end
  // ========================================================
  // read mux
  reg [31:0] rd_q;
  reg [31:0] rd_d;
  always @* begin
    rd_d = `FAP_ZERO32;
    if (hit(idx, `FAP_IDX_CR1)) begin
      rd_d[7:0] = cr1_q;
    end else if (hit(idx, `FAP_IDX_CR2)) begin
      rd_d[`FAP_CR2_OPT] = opt_q;
    end else if (hit(idx, `FAP_IDX_STAT)) begin
      rd_d[`FAP_ST_WPA] = wpa_q;
      rd_d[`FAP_ST_PUL] = pul;
      rd_d[`FAP_ST_EOP] = eop_q;
      rd_d[`FAP_ST_DUL] = data_unlocked_flag;
      rd_d[`FAP_ST_HVOFF] = !prog_busy;
    end else if (hit(idx, `FAP_IDX_CFG)) begin
      rd_d[3:0] = cfg_q;
    end else if (hit(idx, `FAP_IDX_ACC)) begin
      rd_d[2:0] = last_area_q;
      rd_d[3] = last_deny_q;
      rd_d[4] = p_blk;
      rd_d[5] = d_blk;
      rd_d[6] = optul_q;
      rd_d[7] = dbg;
    end
    // key registers fall through to zero
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= `FAP_ZERO32;
    end else if (psel && !penable && !pwrite) begin
      rd_q <= rd_d;
    end
  end
  assign prdata = rd_q;
endmodule // fap_ctrl

// *** verilog/fap_regs.vh ***
`ifndef FAP_REGS_VH
`define FAP_REGS_VH
// ==========================================================
// register offsets (byte addresses, index times four)
`define FAP_IDX_CR1 8'h00
`define FAP_IDX_CR2 8'h01
`define FAP_IDX_PKEY 8'h02
`define FAP_IDX_DKEY 8'h03
`define FAP_IDX_STAT 8'h04
`define FAP_IDX_CFG 8'h05
`define FAP_IDX_ACC 8'h06
`define FAP_IDX_RES 8'h07
`define FAP_OFF_W 10
// ==========================================================
// control register one fields
`define FAP_CR1_RST 8'h00
`define FAP_CR1_FIX 0
`define FAP_CR1_IE 1
`define FAP_CR1_WAIT_LOWLEAK_SELECT 2
`define FAP_CR1_RUNM 3
`define FAP_CR1_MASK 8'h0F
// ==========================================================
// control register two and status fields
`define FAP_CR2_OPT 7
`define FAP_ST_WPA 0
`define FAP_ST_PUL 1
`define FAP_ST_EOP 2
`define FAP_ST_DUL 3
`define FAP_ST_HVOFF 6
// ==========================================================
// key values (defaults, overridable at the top)
`define FAP_KEY1 8'h56
`define FAP_KEY2 8'hAE
`define FAP_ZERO32 32'h0000_0000
// ==========================================================
// access request areas and kinds
`define FAP_AR_VEC 3'h0
`define FAP_AR_TRAP 3'h1
`define FAP_AR_PRIV 3'h2
`define FAP_AR_UBC 3'h3
`define FAP_AR_MAIN 3'h4
`define FAP_AR_DATA 3'h5
`define FAP_AR_OPT 3'h6
`define FAP_AK_RD 2'h0
`define FAP_AK_WR 2'h1
`define FAP_AK_EX 2'h2
// ==========================================================
// programming timing, in nanoseconds
`define FAP_TPROG_NS 3000
`define FAP_CLK_NS 40
`endif

// *** verilog/fap_key_seq.v ***
`timescale 1ns/1ps
`include "fap_regs.vh"
// ==========================================================
// two-byte unlock key sequence tracker
module fap_key_seq #(
  parameter [7:0] KEY1 = `FAP_KEY1,
  parameter [7:0] KEY2 = `FAP_KEY2,
  parameter ONCE = 1'b0
) (
  input wire pclk,
  input wire presetn,
  input wire key_wr,
  input wire [7:0] key_data,
  input wire relock,
  output wire unlocked,
  output wire blocked,
  output wire unlock_pulse
);
  reg first_q;
  reg unl_q;
  reg dead_q;
  reg used_q;
  wire accept;
  assign accept = key_wr && !dead_q && !unl_q && !(ONCE && used_q);
  assign unlock_pulse = accept && first_q && (key_data == KEY2);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q <= 1'b0;
      unl_q <= 1'b0;
      dead_q <= 1'b0;
      used_q <= 1'b0;
    end else begin
      if (unlock_pulse) begin
        unl_q <= 1'b1;
        used_q <= 1'b1;
        first_q <= 1'b0;
      end else if (relock) begin
        unl_q <= 1'b0;
      end
      if (accept && !unlock_pulse) begin
        if (!first_q && key_data == KEY1) begin
          first_q <= 1'b1;
        end else begin
          // wrong key: the program side stays dead until reset
          first_q <= 1'b0;
          if (ONCE) begin
            dead_q <= 1'b1;
          end
        end
      end
    end
  end
  assign blocked = dead_q || (ONCE && used_q);
  assign unlocked = unl_q;
endmodule // fap_key_seq

// *** tb/fap_core_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// core and debug tool: memory requests and mode pins
module fap_core_model (
  input wire pclk,
  input wire acc_grant,
  output reg acc_valid,
  output reg [2:0] acc_area,
  output reg [1:0] acc_kind,
  output reg acc_rop_byte,
  output reg acc_erased,
  output reg debug_active,
  output reg wait_mode,
  output reg run_from_ram,
  output reg privileged
);
  initial begin
    {acc_valid, acc_rop_byte, acc_erased} = 3'h0;
    {acc_area, acc_kind} = 5'h1F;
    {debug_active, wait_mode, run_from_ram, privileged} = 4'h0;
  end
  // mode pins pass a two-flop sync, so give them time to land
  task set_mode(input d, input w, input r, input p);
    begin
      @(posedge pclk);
      {debug_active, wait_mode, run_from_ram, privileged} <= {d, w, r, p};
      repeat (4) @(posedge pclk);
    end
  endtask
  // one-cycle request; qualifiers flip afterwards so stale values show
  task access(input [2:0] a, input [1:0] k, input r, input e, output g);
    begin
      @(posedge pclk);
      acc_valid <= 1'b1;
      {acc_area, acc_kind, acc_rop_byte, acc_erased} <= {a, k, r, e};
      @(posedge pclk);
      acc_valid <= 1'b0;
      {acc_area, acc_kind, acc_rop_byte, acc_erased} <= ~{a, k, r, e};
      #1 g = acc_grant;
    end
  endtask
endmodule // fap_core_model

// *** tb/fap_ctrl_checker.sv ***
`timescale 1ns/1ps
`include "fap_regs.vh"
// ==========================================================
// port checks; cfg and cr1 mirrored from observed bus writes
module fap_ctrl_checker #(
  parameter TPROG_NS = `FAP_TPROG_NS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire debug_active,
  input wire wait_mode,
  input wire privileged,
  input wire acc_valid,
  input wire [2:0] acc_area,
  input wire [1:0] acc_kind,
  input wire acc_rop_byte,
  input wire acc_grant,
  input wire acc_start,
  input wire prog_busy,
  input wire prog_done,
  input wire mem_lowleak,
  input wire mem_irq
);
  localparam int FULL = (TPROG_NS + `FAP_CLK_NS - 1) / `FAP_CLK_NS;
  localparam int HALF = (FULL + 1) / 2;
  reg [2:0] dbg_q, wait_q;
  reg ie_q, wait_lowleak_select_q, rop_q;
  reg [7:0] busy_q;
  wire wr_en = psel && penable && pwrite;
  wire opt_wr = acc_area == `FAP_AR_OPT && acc_kind == `FAP_AK_WR;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {dbg_q, wait_q, ie_q, wait_lowleak_select_q, rop_q, busy_q} <= 17'h0;
    end else begin
      dbg_q <= {dbg_q[1:0], debug_active};
      wait_q <= {wait_q[1:0], wait_mode};
      busy_q <= prog_busy ? busy_q + 8'h01 : 8'h00;
      if (wr_en && paddr == 32'h0000_0000) begin
        {wait_lowleak_select_q, ie_q} <= pwdata[2:1];
      end
      if (wr_en && paddr == 32'h0000_0014) begin
        rop_q <= pwdata[0];
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_high_a: assert property (pready)
    else $error("pready low");
  dbg_block_a: assert property (acc_valid && &dbg_q && rop_q
    && !(opt_wr && acc_rop_byte) |=> !acc_grant) else $error("debug grant");
  opt_read_a: assert property (acc_valid && ~|dbg_q && rop_q
    && acc_area == `FAP_AR_OPT && acc_kind != `FAP_AK_RD |=> !acc_grant)
    else $error("option not read only");
  ubc_no_write_a: assert property (acc_valid && acc_area == `FAP_AR_UBC
    && acc_kind == `FAP_AK_WR |=> !acc_grant) else $error("boot write");
  priv_block_a: assert property (acc_valid && acc_area == `FAP_AR_PRIV
    && (&dbg_q || !privileged) |=> !acc_grant) else $error("priv grant");
  grant_cause_a: assert property (acc_grant |-> $past(acc_valid))
    else $error("grant without request");
  start_grant_a: assert property (acc_start |-> acc_grant)
    else $error("start without grant");
  irq_gate_a: assert property (mem_irq |-> ie_q || $past(ie_q))
    else $error("irq while disabled");
  irq_done_a: assert property (prog_done && ie_q |-> ##[0:2] mem_irq)
    else $error("no irq at end");
  busy_len_a: assert property ($fell(prog_busy)
    |-> busy_q == FULL || busy_q == HALF) else $error("program time");
  wait_ll_a: assert property (&wait_q && wait_lowleak_select_q |-> ##[0:2] mem_lowleak)
    else $error("no wait low leak");
  ll_exit_a: assert property (mem_lowleak && acc_valid && ~|wait_q
    |-> ##[1:2] !mem_lowleak) else $error("low leak kept");
  cover property (acc_grant);
  cover property (prog_done && ie_q);
  cover property ($rose(mem_lowleak));
endmodule // fap_ctrl_checker
bind fap_ctrl fap_ctrl_checker #(.TPROG_NS(TPROG_NS)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .debug_active(debug_active), .wait_mode(wait_mode),
  .privileged(privileged), .acc_valid(acc_valid), .acc_area(acc_area),
  .acc_kind(acc_kind), .acc_rop_byte(acc_rop_byte),
  .acc_grant(acc_grant), .acc_start(acc_start),
  .prog_busy(prog_busy), .prog_done(prog_done),
  .mem_lowleak(mem_lowleak), .mem_irq(mem_irq)
);

// *** tb/test_flash_access_protection_ctrl.sv ***
`timescale 1ns/1ps
`include "fap_regs.vh"
// ==========================================================
// bench: register, lock, timing, low leak and access checks
module test_flash_access_protection_ctrl;
  localparam TPROG_NS = 400;
  localparam [31:0] FULL = TPROG_NS / `FAP_CLK_NS;
  localparam [31:0] HALF = (FULL + 1) / 2;
  localparam [31:0] ALL = 32'hFFFF_FFFF;
  localparam [7:0] A_CR1 = `FAP_IDX_CR1 << 2;
  localparam [7:0] A_CR2 = `FAP_IDX_CR2 << 2;
  localparam [7:0] A_PK = `FAP_IDX_PKEY << 2;
  localparam [7:0] A_DK = `FAP_IDX_DKEY << 2;
  localparam [7:0] A_ST = `FAP_IDX_STAT << 2;
  localparam [7:0] A_CFG = `FAP_IDX_CFG << 2;
  reg pclk, presetn, psel, penable, pwrite, err, g, ers_seen, rd_m, rp;
  reg [31:0] paddr, pwdata, q, n;
  reg [2:0] ra;
  reg [1:0] rk;
  integer seed, miscompares, check_count, i;
  wire [31:0] prdata;
  wire pready, pslverr, dbg, wt, ram, prv, av, arb, aer, gnt;
  wire busy, ll, irq, ers;
  wire [2:0] aa;
  wire [1:0] ak;
  fap_ctrl #(.TPROG_NS(TPROG_NS)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .debug_active(dbg),
    .wait_mode(wt), .run_from_ram(ram), .privileged(prv),
    .acc_valid(av), .acc_area(aa), .acc_kind(ak), .acc_rop_byte(arb),
    .acc_erased(aer), .acc_grant(gnt), .acc_start(), .prog_busy(busy),
    .prog_done(), .mem_lowleak(ll), .mem_irq(irq), .erase_all(ers));
  fap_core_model i_core (
    .pclk(pclk), .acc_grant(gnt), .acc_valid(av), .acc_area(aa),
    .acc_kind(ak), .acc_rop_byte(arb), .acc_erased(aer),
    .debug_active(dbg), .wait_mode(wt), .run_from_ram(ram),
    .privileged(prv));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) if (ers === 1'b1) ers_seen <= 1'b1;
  // ==========================================================
  // checking and closing
  task chk(input [31:0] gv, input [31:0] ev);
    begin
      check_count = check_count + 1;
      if (gv !== ev) begin
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, gv, ev);
      end
    end
  endtask
  task chk_bit(input gv, input ev);
    chk({31'h0, gv}, {31'h0, ev});
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // ten thousand cycles, some sixteen times the expected run
  initial begin
    #400000;
    miscompares = miscompares + 1;
    close_out;
  end
  // ==========================================================
  // bus and request tasks
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, 24'h0, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(q & m, e);
    end
  endtask
  task keys(input [7:0] a, input [7:0] k1, input [7:0] k2);
    begin
      wr(a, {24'h0, k1});
      wr(a, {24'h0, k2});
    end
  endtask
  task acc(input [2:0] a, input [1:0] k, input r, input e, input x);
    begin
      i_core.access(a, k, r, e, g);
      chk_bit(g, x);
    end
  endtask
  task wait_busy;
    for (n = 0; busy === 1'b1 && n < 200; n = n + 1) @(posedge pclk) #1;
  endtask
  task pause;
    repeat (3) @(posedge pclk) #1;
  endtask
  task reset_dut;
    begin
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
    end
  endtask
  // core modes: debug port hides everything under protection
  function exp_re(input [2:0] a, input [1:0] k, input d, r, p);
    if (d && (r || a == `FAP_AR_PRIV)) exp_re = 1'b0;
    else if (a == `FAP_AR_PRIV) exp_re = p;
    else if (a == `FAP_AR_DATA || a == `FAP_AR_OPT) exp_re = k == 2'h0;
    else exp_re = 1'b1;
  endfunction
  // ==========================================================
  // main sequence
  initial begin
    {seed, miscompares, check_count} = {32'd99479, 64'h0};
    {presetn, psel, penable, pwrite, paddr, pwdata, ers_seen} = 69'h0;
    reset_dut;
    rdc(A_CR1, ALL, 32'h00);
    wr(A_CR1, 32'hF7);
    rdc(A_CR1, ALL, 32'h07);
    rdc(8'h40, 32'h0, 32'h0);
    chk_bit(err, 1'b1);
    acc(`FAP_AR_MAIN, `FAP_AK_WR, 1'b0, 1'b0, 1'b0);
    rdc(A_ST, 32'h0F, 32'h01);
    rdc(A_ST, 32'h0F, 32'h00);
    keys(A_PK, `FAP_KEY1, `FAP_KEY2);
    rdc(A_ST, 32'h02, 32'h02);
    rdc(A_PK, ALL, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      wr(A_CR1, {30'h0, i == 3, i == 2});
      acc(`FAP_AR_MAIN, `FAP_AK_WR, 1'b0, i != 0, 1'b1);
      wait_busy;
      chk(n, (i == 1 || i == 3) ? HALF : FULL);
      pause;
      chk_bit(irq, i == 3);
      rdc(A_ST, 32'h04, 32'h04);
      rdc(A_ST, 32'h04, 32'h00);
    end
    pause;
    chk_bit(irq, 1'b0);
    wr(A_CFG, 32'h6);
    acc(`FAP_AR_TRAP, `FAP_AK_WR, 1'b0, 1'b1, 1'b0);
    acc(`FAP_AR_VEC, `FAP_AK_WR, 1'b0, 1'b1, 1'b0);
    wr(A_CFG, 32'h0);
    acc(`FAP_AR_UBC, `FAP_AK_WR, 1'b0, 1'b1, 1'b0);
    acc(`FAP_AR_VEC, `FAP_AK_WR, 1'b0, 1'b1, 1'b1);
    wait_busy;
    wr(A_ST, 32'h0);
    rdc(A_ST, 32'h0A, 32'h00);
    acc(`FAP_AR_MAIN, `FAP_AK_WR, 1'b0, 1'b0, 1'b0);
    keys(A_PK, `FAP_KEY1, `FAP_KEY2);
    rdc(A_ST, 32'h0B, 32'h01);
    wr(A_DK, 32'h11);
    keys(A_DK, `FAP_KEY1, `FAP_KEY2);
    rdc(A_ST, 32'h08, 32'h08);
    acc(`FAP_AR_DATA, `FAP_AK_WR, 1'b0, 1'b1, 1'b1);
    wait_busy;
    acc(`FAP_AR_OPT, `FAP_AK_WR, 1'b0, 1'b1, 1'b0);
    wr(A_ST, 32'h0);
    acc(`FAP_AR_DATA, `FAP_AK_WR, 1'b0, 1'b1, 1'b0);
    wr(A_CR2, 32'h80);
    keys(A_DK, `FAP_KEY1, `FAP_KEY2);
    acc(`FAP_AR_OPT, `FAP_AK_WR, 1'b0, 1'b1, 1'b1);
    wait_busy;
    wr(A_ST, 32'h0);
    wr(A_CR2, 32'h0);
    i_core.set_mode(1'b0, 1'b0, 1'b1, 1'b0);
    wr(A_CR1, 32'h8);
    pause;
    chk_bit(ll, 1'b1);
    acc(`FAP_AR_MAIN, `FAP_AK_RD, 1'b0, 1'b0, 1'b1);
    pause;
    chk_bit(ll, 1'b0);
    rdc(A_CR1, ALL, 32'h0);
    wr(A_CR1, 32'h8);
    wr(A_CR1, 32'h0);
    pause;
    chk_bit(ll, 1'b1);
    acc(`FAP_AR_MAIN, `FAP_AK_RD, 1'b0, 1'b0, 1'b1);
    i_core.set_mode(1'b0, 1'b1, 1'b0, 1'b0);
    wr(A_CR1, 32'h4);
    pause;
    chk_bit(ll, 1'b1);
    wr(A_CR1, 32'h0);
    pause;
    chk_bit(ll, 1'b0);
    for (i = 0; i < 40; i = i + 1) begin
      if (i % 20 == 0) wr(A_CFG, {29'h1, 2'h0, i >= 20});
      ra = 3'({$random(seed)} % 7);
      rk = ({$random(seed)} % 2 == 1) ? `FAP_AK_EX : `FAP_AK_RD;
      {rd_m, rp} = 2'($random(seed));
      i_core.set_mode(rd_m, 1'b0, 1'b0, rp);
      acc(ra, rk, rp, 1'b0, exp_re(ra, rk, rd_m, i >= 20, rp));
    end
    i_core.set_mode(1'b0, 1'b0, 1'b0, 1'b0);
    acc(`FAP_AR_OPT, `FAP_AK_EX, 1'b0, 1'b0, 1'b0);
    ers_seen = 1'b0;
    wr(A_CFG, 32'h4);
    pause;
    chk_bit(ers_seen, 1'b1);
    reset_dut;
    keys(A_PK, 8'h11, `FAP_KEY1);
    wr(A_PK, {24'h0, `FAP_KEY2});
    rdc(A_ST, 32'h02, 32'h00);
    reset_dut;
    keys(A_PK, `FAP_KEY1, `FAP_KEY2);
    rdc(A_ST, 32'h02, 32'h02);
    close_out;
  end
endmodule // test_flash_access_protection_ctrl
